// ===== verilog/scrb_pkg.sv
// Constants for the synthesizer configuration register bank.
// Assumes a 32-bit serial word whose low three bits select the latch.
//
// How it works
// RULE_01: Serial word shifted MSB first, rising edge
// RULE_02: Load strobe rise copies word to latch
// RULE_03: Buffered settings wait for register zero write
// RULE_04: Select zero loads integer and fraction high
// RULE_05: Select one loads fraction low part
// RULE_06: Select two loads reference divider settings
// RULE_07: Register zero top bit enables ramp
// RULE_08: Bits 30 to 27 pick mux output
// RULE_09: Twelve bits give integer divide value
// RULE_10: Fraction from zero bits 14:3, one 27:15
// RULE_11: Fraction equals low plus high times 8192
// RULE_12: Host writes reserved bits as zero
// RULE_13: Divider bit enables cycle slip reduction
// RULE_14: Slip reduction needs even duty, low current
// RULE_15: Slip reduction needs positive detector polarity
// RULE_16: Divider bits 27 to 24 set pump current
// RULE_17: Host picks 8/9 prescaler above 3 GHz
// RULE_18: Host keeps division at least 23 or 75
// RULE_19: Write-only latches, only selected one changes

package scrb_pkg;

    localparam int WORD_W = 32;
    localparam int SEL_W = 3;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [1:0] SYNC_RESET = 2'h0;

    // Latch select codes
    localparam logic [2:0] SEL_INT_FRACTIONAL_DIVIDE_VALUE = 3'h0;
    localparam logic [2:0] SEL_FRACTIONAL_DIVIDE_VALUE_LOW = 3'h1;
    localparam logic [2:0] SEL_REF_DIV = 3'h2;
    localparam logic [2:0] SEL_DEVIATION = 3'h5;
    localparam logic [2:0] SEL_STEP = 3'h6;
    localparam logic [2:0] SEL_DELAY = 3'h7;

    // Register zero fields
    localparam int R0_RAMP = 31;
    localparam int R0_MUX_LSB = 27;
    localparam int R0_INT_LSB = 15;
    localparam int R0_FRACH_LSB = 3;

    // Register one and two fields
    localparam int R1_FRACL_LSB = 15;
    localparam int R2_SLIP = 28;
    localparam int R2_PUMP_LSB = 24;
    localparam int R2_PRESC = 22;
    localparam int R2_HALVE = 21;
    localparam int R2_DOUBLE = 20;
    localparam int R2_RCNT_LSB = 15;
    localparam int R2_CLK1_LSB = 3;

    // Deviation, step and delay word fields
    localparam int R5_TXCLK = 29;
    localparam int R5_PARAB = 28;
    localparam int R5_IRQ_LSB = 26;
    localparam int R5_FSKRAMP = 25;
    localparam int R5_RAMP2 = 24;
    localparam int R5_DEVSEL = 23;
    localparam int R5_DOFF_LSB = 19;
    localparam int R5_DEV_LSB = 3;
    localparam int R6_STEPSEL = 23;
    localparam int R6_STEP_LSB = 3;
    localparam int R7_FAST = 18;
    localparam int R7_RDEL = 17;
    localparam int R7_DCLK = 16;
    localparam int R7_DSE = 15;
    localparam int R7_DST_LSB = 3;

    // Double-buffered group layout of register two
    localparam int DB2_W = 11;
    localparam logic [12:0] FRACL_RESET = 13'h0000;
    localparam logic [10:0] DB2_RESET = 11'h000;

endpackage

// ===== verilog/scrb_serial_in.sv
// Serial word receiver: shift register on the serial clock, load strobe
// synchronised into the core clock. Assumes the host keeps the serial
// clock still while the strobe is high, so the word is stable then.
`timescale 1ns/1ps
`default_nettype none

module scrb_serial_in (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_strobe,
    output logic [31:0] word,
    output logic word_valid
);

    logic [31:0] shift_q;
    logic [1:0] strobe_sync;
    logic strobe_seen;
    logic strobe_rise;

    // ========================================
    // Link domain
    // Shift in MSB first on each rising serial clock edge
    always_ff @(posedge serial_clk)
    begin
        shift_q <= {shift_q[30:0], serial_data}; // [RULE_01]
    end

    // ========================================
    // Core domain
    // Two-flop synchroniser for the strobe, then a delay for edge detect
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            strobe_sync <= scrb_pkg::SYNC_RESET;
            strobe_seen <= 1'b0;
        end
        else
        begin
            strobe_sync <= {strobe_sync[0], load_strobe};
            strobe_seen <= strobe_sync[1];
        end
    end

    assign strobe_rise = strobe_sync[1] & ~strobe_seen;

    // Take the quiet shift register on the strobe's rising edge
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            word <= scrb_pkg::WORD_RESET;
            word_valid <= 1'b0;
        end
        else
        begin
            word_valid <= strobe_rise; // [RULE_02]
            if (strobe_rise)
                word <= shift_q;
        end
    end

endmodule // scrb_serial_in

`default_nettype wire

// ===== verilog/scrb_dbuf.sv
// Double-buffer stage: a pending copy written by its own load and an
// active copy that follows only on commit. Single core clock domain.
`timescale 1ns/1ps
`default_nettype none

module scrb_dbuf #(
    parameter int W = 13,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [W-1:0] data,
    input wire logic commit,
    output logic [W-1:0] pending,
    output logic [W-1:0] active
);

    // Pending copy follows its own latch load
    always_ff @(posedge core_clk)
    begin
        if (reset)
            pending <= INIT;
        else if (load)
            pending <= data;
    end

    // Active copy moves only on a register zero write
    always_ff @(posedge core_clk)
    begin
        if (reset)
            active <= INIT;
        else if (commit)
            active <= load ? data : pending; // [RULE_03]
    end

endmodule // scrb_dbuf

`default_nettype wire

// ===== verilog/scrb_config_bank.sv
// Configuration register bank top: serial load, latch decode, double
// buffering and field outputs. Assumes a host on the three-wire link.
`timescale 1ns/1ps
`default_nettype none

module scrb_config_bank (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_strobe,
    output logic ramp_enable,
    output logic [3:0] mux_output_select,
    output logic [11:0] int_divide_value,
    output logic [24:0] fractional_divide_value,
    output logic commit_pulse,
    output logic slip_reduction_enable,
    output logic [3:0] pump_current,
    output logic prescaler_choice,
    output logic ref_halve_enable,
    output logic ref_double_enable,
    output logic [4:0] ref_counter,
    output logic [11:0] step_clock_divider,
    output logic tx_ramp_clock,
    output logic parabolic_ramp,
    output logic [1:0] interrupt_mode,
    output logic fsk_ramp_enable,
    output logic ramp2_enable,
    output logic deviation_select,
    output logic [3:0] deviation_offset,
    output logic [15:0] deviation_word,
    output logic step_select,
    output logic [19:0] step_word,
    output logic ramp_delay_fast,
    output logic ramp_delay,
    output logic delay_clock_select,
    output logic delay_start_enable,
    output logic [11:0] delay_start
);

    logic [31:0] word;
    logic word_valid;
    logic [2:0] sel;
    logic load_r0;
    logic load_r1;
    logic load_r2;
    logic [11:0] fractional_divide_value_high;
    logic [12:0] fractional_divide_value_low_pend;
    logic [12:0] fractional_divide_value_low;
    logic [10:0] db2_pend;
    logic [10:0] db2_act;

    // ========================================
    // Serial capture
    scrb_serial_in u_serial (
        .core_clk(core_clk),
        .reset(reset),
        .serial_clk(serial_clk),
        .serial_data(serial_data),
        .load_strobe(load_strobe),
        .word(word),
        .word_valid(word_valid)
    );

    // ========================================
    // Latch select decode
    assign sel = word[scrb_pkg::SEL_W-1:0]; // [RULE_02]
    assign load_r0 = word_valid && sel == scrb_pkg::SEL_INT_FRACTIONAL_DIVIDE_VALUE; // [RULE_04]
    assign load_r1 = word_valid && sel == scrb_pkg::SEL_FRACTIONAL_DIVIDE_VALUE_LOW; // [RULE_05]
    assign load_r2 = word_valid && sel == scrb_pkg::SEL_REF_DIV; // [RULE_06]

    // ========================================
    // Register zero: immediate fields
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ramp_enable <= 1'b0;
            mux_output_select <= 4'h0;
            int_divide_value <= 12'h000;
            fractional_divide_value_high <= 12'h000;
        end
        else if (load_r0) // [RULE_19]
        begin
            ramp_enable <= word[scrb_pkg::R0_RAMP]; // [RULE_07]
            mux_output_select <= word[scrb_pkg::R0_MUX_LSB +: 4]; // [RULE_08]
            int_divide_value <= word[scrb_pkg::R0_INT_LSB +: 12]; // [RULE_09]
            fractional_divide_value_high <= word[scrb_pkg::R0_FRACH_LSB +: 12]; // [RULE_10]
        end
    end

    // Commit pulse marks the cycle buffered values go live
    always_ff @(posedge core_clk)
    begin
        if (reset)
            commit_pulse <= 1'b0;
        else
            commit_pulse <= load_r0; // [RULE_03]
    end

    // ========================================
    // Double-buffered fraction low part
    scrb_dbuf #(
        .W(13),
        .INIT(scrb_pkg::FRACL_RESET)
    ) u_fractional_divide_value_low (
        .core_clk(core_clk),
        .reset(reset),
        .load(load_r1),
        .data(word[scrb_pkg::R1_FRACL_LSB +: 13]), // [RULE_10]
        .commit(load_r0),
        .pending(fractional_divide_value_low_pend),
        .active(fractional_divide_value_low)
    );

    // Fraction = low + high * 2^13, both parts from flops
    assign fractional_divide_value = {fractional_divide_value_high, fractional_divide_value_low}; // [RULE_11]

    // ========================================
    // Double-buffered divider group: pump, halve, double, counter
    scrb_dbuf #(
        .W(scrb_pkg::DB2_W),
        .INIT(scrb_pkg::DB2_RESET)
    ) u_ref_div (
        .core_clk(core_clk),
        .reset(reset),
        .load(load_r2),
        .data({word[scrb_pkg::R2_PUMP_LSB +: 4], // [RULE_16]
               word[scrb_pkg::R2_HALVE],
               word[scrb_pkg::R2_DOUBLE],
               word[scrb_pkg::R2_RCNT_LSB +: 5]}),
        .commit(load_r0),
        .pending(db2_pend),
        .active(db2_act)
    );

    assign pump_current = db2_act[10:7];
    assign ref_halve_enable = db2_act[6];
    assign ref_double_enable = db2_act[5];
    assign ref_counter = db2_act[4:0];

    // Divider register fields that act at once
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            slip_reduction_enable <= 1'b0;
            prescaler_choice <= 1'b0;
            step_clock_divider <= 12'h000;
        end
        else if (load_r2)
        begin
            slip_reduction_enable <= word[scrb_pkg::R2_SLIP]; // [RULE_13]
            prescaler_choice <= word[scrb_pkg::R2_PRESC];
            step_clock_divider <= word[scrb_pkg::R2_CLK1_LSB +: 12];
        end
    end

    // ========================================
    // Deviation word
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            tx_ramp_clock <= 1'b0;
            parabolic_ramp <= 1'b0;
            interrupt_mode <= 2'h0;
            fsk_ramp_enable <= 1'b0;
            ramp2_enable <= 1'b0;
            deviation_select <= 1'b0;
            deviation_offset <= 4'h0;
            deviation_word <= 16'h0000;
        end
        else if (word_valid && sel == scrb_pkg::SEL_DEVIATION) // [RULE_19]
        begin
            tx_ramp_clock <= word[scrb_pkg::R5_TXCLK];
            parabolic_ramp <= word[scrb_pkg::R5_PARAB];
            interrupt_mode <= word[scrb_pkg::R5_IRQ_LSB +: 2];
            fsk_ramp_enable <= word[scrb_pkg::R5_FSKRAMP];
            ramp2_enable <= word[scrb_pkg::R5_RAMP2];
            deviation_select <= word[scrb_pkg::R5_DEVSEL];
            deviation_offset <= word[scrb_pkg::R5_DOFF_LSB +: 4];
            deviation_word <= word[scrb_pkg::R5_DEV_LSB +: 16];
        end
    end

    // Step word
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            step_select <= 1'b0;
            step_word <= 20'h0_0000;
        end
        else if (word_valid && sel == scrb_pkg::SEL_STEP) // [RULE_19]
        begin
            step_select <= word[scrb_pkg::R6_STEPSEL];
            step_word <= word[scrb_pkg::R6_STEP_LSB +: 20];
        end
    end

    // Delay word
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ramp_delay_fast <= 1'b0;
            ramp_delay <= 1'b0;
            delay_clock_select <= 1'b0;
            delay_start_enable <= 1'b0;
            delay_start <= 12'h000;
        end
        else if (word_valid && sel == scrb_pkg::SEL_DELAY) // [RULE_19]
        begin
            ramp_delay_fast <= word[scrb_pkg::R7_FAST];
            ramp_delay <= word[scrb_pkg::R7_RDEL];
            delay_clock_select <= word[scrb_pkg::R7_DCLK];
            delay_start_enable <= word[scrb_pkg::R7_DSE];
            delay_start <= word[scrb_pkg::R7_DST_LSB +: 12];
        end
    end

    // ========================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_strobe_to_load: assert property ( // [RULE_02]
        $rose(load_strobe) ##1 load_strobe ##1 load_strobe
        |-> ##[0:2] word_valid)
        else $error("load strobe rise not followed by a load");

    a_ramp_bit_load: assert property ( // [RULE_07]
        load_r0 |=> ramp_enable == $past(word[31]))
        else $error("ramp enable does not follow top bit");

    a_mux_sel_load: assert property ( // [RULE_08]
        load_r0 |=> mux_output_select == $past(word[30:27]))
        else $error("mux select does not follow bits 30 to 27");

    a_int_value_load: assert property ( // [RULE_09]
        load_r0 |=> int_divide_value == $past(word[26:15]))
        else $error("integer value not loaded");

    a_fractional_divide_value_commit: assert property ( // [RULE_10]
        load_r0 |=> fractional_divide_value[12:0] == $past(fractional_divide_value_low_pend)
            && fractional_divide_value[24:13] == $past(word[14:3]))
        else $error("fraction not assembled on commit");

    a_fractional_divide_value_low_pend: assert property ( // [RULE_05]
        load_r1 |=> fractional_divide_value_low_pend == $past(word[27:15]))
        else $error("fraction low part not held as pending");

    a_fractional_divide_value_low_held: assert property ( // [RULE_03]
        load_r1 |=> $stable(fractional_divide_value))
        else $error("fraction low part acted before commit");

    a_pump_held: assert property ( // [RULE_03]
        load_r2 |=> $stable(pump_current) && $stable(ref_counter))
        else $error("buffered divider field acted before commit");

    a_slip_bit_load: assert property ( // [RULE_13]
        load_r2 |=> slip_reduction_enable == $past(word[28]))
        else $error("slip reduction enable not loaded");

    a_other_sel_keep: assert property ( // [RULE_19]
        word_valid && sel != scrb_pkg::SEL_INT_FRACTIONAL_DIVIDE_VALUE
        |=> $stable(int_divide_value) && $stable(ramp_enable))
        else $error("register zero fields changed by another latch");

    // Pending divider group and its commit on a register zero write
    a_div_pend: assert property ( // [RULE_06]
        load_r2
        |=> db2_pend == {$past(word[27:24]), $past(word[21:15])})
        else $error("divider group not held as pending");

    a_buffer_commit: assert property ( // [RULE_16]
        load_r0 |=> {pump_current, ref_halve_enable, ref_double_enable,
            ref_counter} == $past(db2_pend))
        else $error("buffered divider group not committed");

    a_presc_load: assert property ( // [RULE_06]
        load_r2 |=> prescaler_choice == $past(word[22]))
        else $error("prescaler choice not loaded");

    // Ramp words land only in their own latch
    a_dev_word_load: assert property ( // [RULE_19]
        word_valid && sel == scrb_pkg::SEL_DEVIATION
        |=> deviation_word == $past(word[18:3]))
        else $error("deviation word not loaded");

    a_step_word_load: assert property ( // [RULE_19]
        word_valid && sel == scrb_pkg::SEL_STEP
        |=> step_word == $past(word[22:3]))
        else $error("step word not loaded");

    a_delay_load: assert property ( // [RULE_19]
        word_valid && sel == scrb_pkg::SEL_DELAY
        |=> delay_start == $past(word[14:3]))
        else $error("delay start not loaded");

    c_r0_load: cover property (load_r0);
    c_r1_then_commit: cover property (load_r1 ##[1:100] load_r0);
    c_slip_on: cover property (load_r2 && word[28]);
    c_buffered_commit: cover property (load_r2 ##[1:200] load_r0);
    c_deviation_load: cover property (
        word_valid && sel == scrb_pkg::SEL_DEVIATION);

endmodule // scrb_config_bank

`default_nettype wire

// ===== testbench/scrb_host_model.sv
// Host model for the three-wire configuration link.
// Assumes the bench calls send_word; the link clock stands still between
// frames and the data line never keeps showing the last bit once released.
`timescale 1ns/1ps
`default_nettype none

module scrb_host_model (
    output logic serial_clk,
    output logic serial_data,
    output logic load_strobe
);
    // ==================================================
    // Idle levels
    initial
    begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end

    // Shift one word MSB first, then pulse the strobe; half sets the pace
    task automatic send_word(input logic [31:0] w, input int half);
        #7; // Phase unrelated to the core clock
        for (int i = 31; i >= 0; i--)
        begin
            serial_data = w[i];
            #(half);
            serial_clk = 1'b1;
            #(half);
            serial_clk = 1'b0;
        end
        serial_data = ~w[0]; // Released line shows no stale bit
        #(half);
        load_strobe = 1'b1;
        #200;
        load_strobe = 1'b0;
        #200;
    endtask
endmodule // scrb_host_model
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the configuration register bank.
// Assumes the host model on the link and a 25 MHz core clock.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic core_clk;
    logic reset;
    wire serial_clk;
    wire serial_data;
    wire load_strobe;
    logic ramp_enable, commit_pulse, slip_reduction_enable, prescaler_choice;
    logic ref_halve_enable, ref_double_enable, tx_ramp_clock, parabolic_ramp;
    logic fsk_ramp_enable, ramp2_enable, deviation_select, step_select;
    logic ramp_delay_fast, ramp_delay, delay_clock_select, delay_start_enable;
    logic [3:0] mux_output_select, pump_current, deviation_offset;
    logic [11:0] int_divide_value, step_clock_divider, delay_start;
    logic [24:0] fractional_divide_value;
    logic [4:0] ref_counter;
    logic [1:0] interrupt_mode;
    logic [15:0] deviation_word;
    logic [19:0] step_word;
    int num_errors = 0;
    int tests_run = 0;
    int commits = 0;

    // ==================================================
    // Design and host
    scrb_config_bank dut (
        .core_clk(core_clk), .reset(reset), .serial_clk(serial_clk),
        .serial_data(serial_data), .load_strobe(load_strobe),
        .ramp_enable(ramp_enable), .mux_output_select(mux_output_select),
        .int_divide_value(int_divide_value),
        .fractional_divide_value(fractional_divide_value),
        .commit_pulse(commit_pulse),
        .slip_reduction_enable(slip_reduction_enable),
        .pump_current(pump_current), .prescaler_choice(prescaler_choice),
        .ref_halve_enable(ref_halve_enable),
        .ref_double_enable(ref_double_enable), .ref_counter(ref_counter),
        .step_clock_divider(step_clock_divider),
        .tx_ramp_clock(tx_ramp_clock), .parabolic_ramp(parabolic_ramp),
        .interrupt_mode(interrupt_mode), .fsk_ramp_enable(fsk_ramp_enable),
        .ramp2_enable(ramp2_enable), .deviation_select(deviation_select),
        .deviation_offset(deviation_offset),
        .deviation_word(deviation_word), .step_select(step_select),
        .step_word(step_word), .ramp_delay_fast(ramp_delay_fast),
        .ramp_delay(ramp_delay), .delay_clock_select(delay_clock_select),
        .delay_start_enable(delay_start_enable), .delay_start(delay_start)
    );
    scrb_host_model host (
        .serial_clk(serial_clk),
        .serial_data(serial_data),
        .load_strobe(load_strobe)
    );

    // ==================================================
    // Clock and commit pulse counter
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        if (reset === 1'b0 && commit_pulse === 1'b1)
            commits <= commits + 1;
    end

    // ==================================================
    // Compare and closing
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ==================================================
    // Scenarios
    task automatic t_reset();
        check({ramp_enable, mux_output_select}, '0);
        check(int_divide_value, '0);
        check(fractional_divide_value, '0);
        check({pump_current, ref_counter, step_word}, '0);
    endtask

    // Register zero fields land at once and raise one commit
    task automatic t_reg_zero();
        logic [31:0] w;
        int c;
        c = commits;
        w = {1'b1, 4'hA, 12'h05A3, 12'h0C35, 3'h0}; // No reserved
        host.send_word(w, 40);
        check({ramp_enable, mux_output_select}, w[31:27]);
        check(int_divide_value, w[26:15]);
        check(fractional_divide_value, {12'h0C35, 13'h0000});
        check(commits - c, 1);
    endtask

    // Buffered fields wait for the next register zero write
    task automatic t_double_buffer();
        logic [31:0] w;
        int c;
        w = {4'h0, 13'h1ABC, 12'h000, 3'h1};
        host.send_word(w, 40);
        check(fractional_divide_value, {12'h0C35, 13'h0000});
        // Prescaler 8/9 chosen for a high input frequency
        w = {4'h0, 4'h7, 2'h1, 2'h3, 5'h13, 12'h09E1, 3'h2};
        host.send_word(w, 40);
        check(prescaler_choice, w[22]);
        check(step_clock_divider, w[14:3]);
        check({pump_current, ref_halve_enable, ref_counter}, '0);
        c = commits;
        // Integer 75 is the floor with the 8/9 prescaler
        w = {1'b0, 4'h3, 12'h004B, 12'h0001, 3'h0};
        host.send_word(w, 40);
        check({pump_current, ref_halve_enable}, {4'h7, 1'b1});
        check({ref_double_enable, ref_counter}, {1'b1, 5'h13});
        check(fractional_divide_value, 32'h1ABC + 32'h1 * 8192);
        check(commits - c, 1);
    endtask

    // Slip reduction acts at once, pump current stays pending
    task automatic t_slip();
        logic [31:0] w;
        // Halved ref, least current, positive polarity
        w = {4'h1, 4'h0, 2'h1, 2'h2, 5'h02, 12'h09E1, 3'h2};
        host.send_word(w, 40);
        check(slip_reduction_enable, 1);
        check({pump_current, ref_halve_enable}, {4'h7, 1'b1});
    endtask

    // Ramp words, then ignored selects leave every latch alone
    task automatic t_ramp_words();
        logic [31:0] w5;
        logic [31:0] w6;
        logic [31:0] w7;
        int c;
        w5 = {2'h0, 2'h2, 2'h2, 3'h5, 4'h9, 16'hBEEF, 3'h5};
        w6 = {8'h00, 1'b1, 20'hA_BCDE, 3'h6};
        w7 = {13'h0000, 4'hB, 12'h05C7, 3'h7};
        host.send_word(w5, 40);
        host.send_word(w6, 40);
        host.send_word(w7, 40);
        c = commits;
        // Selects three and four, with many other bits set
        host.send_word(32'h0000_CFFB, 40);
        host.send_word(32'hFDFF_FF84, 40);
        check({tx_ramp_clock, parabolic_ramp}, w5[29:28]);
        check(interrupt_mode, w5[27:26]);
        check({fsk_ramp_enable, ramp2_enable}, w5[25:24]);
        check(deviation_select, w5[23]);
        check({deviation_offset, deviation_word}, w5[22:3]);
        check({step_select, step_word}, w6[23:3]);
        check({ramp_delay_fast, ramp_delay}, w7[18:17]);
        check(delay_clock_select, w7[16]);
        check(delay_start_enable, w7[15]);
        check(delay_start, w7[14:3]);
        check(int_divide_value, 12'h004B);
        check(slip_reduction_enable, 1'b1);
        check(commits - c, 0);
    endtask

    // ==================================================
    // Main sequence and watchdog
    initial
    begin
        reset = 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        t_reset();
        t_reg_zero();
        t_double_buffer();
        t_slip();
        t_ramp_words();
        conclude();
    end

    initial
    begin
        #200_000;
        num_errors++;
        conclude();
    end
endmodule // testbench
`default_nettype wire
